// ==== rtl/mtcsr_file.sv ====
// Overview of operation
// RULE_01: Previous-privilege field reads binary 11; writes to it are ignored.
// RULE_02: Trap copies global enable to previous enable; return restores it.
// RULE_03: Global interrupt enable is a software-writable bit 3.
// RULE_04: Status bits 17, 16:13, 10:8, 6:5, 2:1 and user enables read zero.
// RULE_05: ISA descriptor read-only: XLEN 1, letters C, I, M set.
// RULE_06: Letter F set only with FPU on and float-in-int-regs off.
// RULE_07: Letter X set when custom-extension or cluster parameter is set.
// RULE_08: Interrupt enable holds one writable bit per interrupt line.
// RULE_09: Interrupt pending is read-only and reports each line.
// RULE_10: Trap vector base writable in 31:8, bits 7:2 read zero.
// RULE_11: Trap vector bit 0 selects direct or vectored; bit 1 reads zero.
// RULE_12: Reset loads boot base upper 24 bits, six zeros and 01.
// RULE_13: Traps redirect fetch using trap vector bits 31:8 as base.
// RULE_14: Inhibit bits 0, 2, 3; bit 1 zero; reset sets implemented bits.
// RULE_15: Inhibit bits of unbuilt event counters read zero.
// RULE_16: Event selectors hold 16 bits; upper bits and unbuilt ones read zero.
// RULE_17: Trap saves PC into exception PC, bit 0 zero; return reloads it.
// RULE_18: Cause bit 31 marks interrupt; 5-bit code writable; 30:5 zero.
// RULE_19: Trap value ignores writes and reads zero.
// RULE_20: Trigger select always reads zero in debug and machine modes.
// RULE_21: Trigger data writes from machine mode are discarded.
// RULE_22: Trigger type reads 2; other fixed trigger fields keep fixed values.
// RULE_23: Unsupported values in legal fields never raise illegal instruction.
// RULE_24: Hardwired fields keep value while writable fields of register update.
`timescale 1ns/1ns
`default_nettype none
module mtcsr_file
    import mtcsr_pkg::*;
#(
    parameter int FPU_PARAM                = 0,
    parameter int FLOAT_IN_INT_REGS_PARAM  = 0,
    parameter int CUSTOM_EXTENSION_PARAM   = 0,
    parameter int CLUSTER_PARAM            = 0,
    parameter int NUM_EVENT_COUNTERS       = 1
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [31:0] boot_trap_base,
    input  wire mtcsr_req_t  csr_req,
    input  wire mtcsr_trap_t trap_in,
    input  wire logic        mret_in,
    input  wire logic [31:0] irq_lines,
    output logic [31:0]      csr_rdata,
    output logic             csr_rvalid,
    output logic             csr_illegal,
    output logic             fetch_redirect,
    output logic [31:0]      fetch_target,
    output logic             global_irq_enable,
    output logic [31:0]      irq_enable_mask,
    output logic [31:0]      counter_inhibit_out,
    output logic             trigger_execute_enable
);

    localparam logic [31:0] IMPL_INHIBIT =
        (32'h0000_0001 << INH_CYCLE_BIT) | (32'h0000_0001 << INH_RETIRED_BIT)
        | (((32'h0000_0001 << NUM_EVENT_COUNTERS) - 32'h0000_0001) << INH_EVENT_LO); // RULE_15

    localparam logic [31:0] ISA_VALUE =
        ({30'h0, ISA_XLEN_32} << ISA_XLEN_LO)
        | (32'h0000_0001 << ISA_BIT_C) | (32'h0000_0001 << ISA_BIT_I)
        | (32'h0000_0001 << ISA_BIT_M)                                              // RULE_05
        | (((FPU_PARAM == 1) && (FLOAT_IN_INT_REGS_PARAM == 0)) ?
           (32'h0000_0001 << ISA_BIT_F) : 32'h0000_0000)                            // RULE_06
        | (((CUSTOM_EXTENSION_PARAM == 1) || (CLUSTER_PARAM == 1)) ?
           (32'h0000_0001 << ISA_BIT_X) : 32'h0000_0000);                           // RULE_07

    mtcsr_state_t st_ff;
    mtcsr_state_t nxt_st;

    logic [31:0] status_view;
    logic [31:0] tvec_view;
    logic [31:0] cause_view;
    logic [31:0] cur_val;
    logic [31:0] new_val;
    logic        known;
    logic        writes;
    int          ev_idx;

    always_comb begin
        status_view = 32'h0000_0000;                                                // RULE_04
        status_view[MST_PREV_PRIV_LO +: 2] = MST_PREV_PRIV_VALUE;                  // RULE_01
        status_view[MST_PREV_ENABLE_BIT]   = st_ff.prev_gie;
        status_view[MST_GLOBAL_ENABLE_BIT] = st_ff.gie;
        tvec_view  = {st_ff.tvec_base, TVEC_LOW_ZERO, 1'b0, st_ff.tvec_mode};      // RULE_10 RULE_11
        cause_view = {st_ff.cause_int, 26'h0, st_ff.cause_code};                    // RULE_18
        ev_idx     = int'(csr_req.addr - ADDR_EVENT_SEL_FIRST);
    end

    always_comb begin
        known   = 1'b1;
        cur_val = 32'h0000_0000;
        case (csr_req.addr)
            ADDR_MACHINE_STATUS:    cur_val = status_view;
            ADDR_ISA_DESCRIPTOR:    cur_val = ISA_VALUE;
            ADDR_INTERRUPT_ENABLE:  cur_val = st_ff.irq_en;
            ADDR_TRAP_VECTOR_BASE:  cur_val = tvec_view;
            ADDR_COUNTER_INHIBIT:   cur_val = st_ff.inhibit & IMPL_INHIBIT;        // RULE_15
            ADDR_TRAP_SCRATCH:      cur_val = st_ff.scratch;
            ADDR_EXCEPTION_PC:      cur_val = {st_ff.epc, 1'b0};                    // RULE_17
            ADDR_TRAP_CAUSE:        cur_val = cause_view;
            ADDR_TRAP_VALUE:        cur_val = 32'h0000_0000;                        // RULE_19
            ADDR_INTERRUPT_PENDING: cur_val = st_ff.pending;
            ADDR_TRIGGER_SELECT:    cur_val = 32'h0000_0000;                        // RULE_20
            ADDR_TRIGGER_DATA_ONE:  cur_val = {TRIG_TYPE_MATCH, TRIG_FIXED_VALUE[27:3],
                                               st_ff.trig_execute, TRIG_FIXED_VALUE[1:0]}; // RULE_22
            default: begin
                if ((csr_req.addr >= ADDR_EVENT_SEL_FIRST) && (csr_req.addr <= ADDR_EVENT_SEL_LAST)) begin
                    if (ev_idx < NUM_EVENT_COUNTERS) begin
                        cur_val = {16'h0000, st_ff.evsel[ev_idx]};                  // RULE_16
                    end
                end else begin
                    known = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        case (csr_req.op)
            MTCSR_OP_WRITE: new_val = csr_req.wdata;
            MTCSR_OP_SET:   new_val = cur_val | csr_req.wdata;
            MTCSR_OP_CLEAR: new_val = cur_val & ~csr_req.wdata;
            default:        new_val = cur_val;
        endcase
        // Set/clear with zero operand is a pure read
        writes = csr_req.valid && known && (csr_req.op == MTCSR_OP_WRITE || csr_req.wdata != 32'h0000_0000);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.irq_sync1 = irq_lines;
        nxt_st.irq_sync2 = st_ff.irq_sync1;
        nxt_st.irq_sync3 = st_ff.irq_sync2;
        // Change taken only once the second and third stages agree
        nxt_st.pending = (st_ff.pending & (st_ff.irq_sync2 ^ st_ff.irq_sync3))
                         | (st_ff.irq_sync2 & st_ff.irq_sync3 & IRQ_LINE_MASK);     // RULE_09
        nxt_st.pending = nxt_st.pending & IRQ_LINE_MASK;
        nxt_st.rvalid   = csr_req.valid;
        nxt_st.rdata    = csr_req.valid ? cur_val : 32'h0000_0000;
        nxt_st.illegal  = csr_req.valid && !known;                                   // RULE_23
        nxt_st.redirect = 1'b0;
        // Vector base captured after reset, boot port only sampled here
        nxt_st.tvec_ready = 1'b1;
        if (!st_ff.tvec_ready) begin
            nxt_st.tvec_base = boot_trap_base[31:8];                                 // RULE_12
            nxt_st.tvec_mode = TVEC_RESET_MODE[0];                                   // RULE_12
        end

        if (writes) begin
            case (csr_req.addr)
                ADDR_MACHINE_STATUS: begin
                    // Previous enable is hardware-owned; only traps and returns move it
                    nxt_st.gie      = new_val[MST_GLOBAL_ENABLE_BIT];               // RULE_03 RULE_24
                end
                ADDR_INTERRUPT_ENABLE: nxt_st.irq_en = new_val & IRQ_LINE_MASK;     // RULE_08
                ADDR_TRAP_VECTOR_BASE: begin
                    nxt_st.tvec_base = new_val[31:TVEC_BASE_LO];                     // RULE_10
                    nxt_st.tvec_mode = new_val[0];                                   // RULE_11
                end
                ADDR_COUNTER_INHIBIT: nxt_st.inhibit = new_val & IMPL_INHIBIT;      // RULE_14
                ADDR_TRAP_SCRATCH:    nxt_st.scratch = new_val;
                ADDR_EXCEPTION_PC:    nxt_st.epc = new_val[31:1];                    // RULE_17
                ADDR_TRAP_CAUSE: begin
                    nxt_st.cause_int  = new_val[CAUSE_INT_BIT];                      // RULE_18
                    nxt_st.cause_code = new_val[CAUSE_CODE_W-1:0];                   // RULE_23
                end
                ADDR_TRIGGER_DATA_ONE: begin
                    if (csr_req.debug_mode) begin
                        nxt_st.trig_execute = new_val[TRIG_EXECUTE_BIT];             // RULE_21
                    end
                end
                default: begin
                    if (csr_req.addr >= ADDR_EVENT_SEL_FIRST && ev_idx < NUM_EVENT_COUNTERS
                        && csr_req.addr <= ADDR_EVENT_SEL_LAST) begin
                        nxt_st.evsel[ev_idx] = new_val[EVSEL_WIDTH-1:0];             // RULE_16
                    end
                end
            endcase
        end

        // Trap and return override a simultaneous CSR write
        if (trap_in.take) begin
            nxt_st.prev_gie   = st_ff.gie;                                           // RULE_02
            nxt_st.gie        = 1'b0;
            nxt_st.epc        = trap_in.pc[31:1];                                    // RULE_17
            nxt_st.cause_int  = trap_in.interrupt;                                   // RULE_18
            nxt_st.cause_code = trap_in.code;
            nxt_st.redirect   = 1'b1;
            nxt_st.redirect_pc = {st_ff.tvec_base, 8'h00};                           // RULE_13
            if (st_ff.tvec_mode && trap_in.interrupt) begin
                nxt_st.redirect_pc = {st_ff.tvec_base, 1'b0, trap_in.code, 2'b00};   // RULE_13
            end
        end else if (mret_in) begin
            nxt_st.gie         = st_ff.prev_gie;                                     // RULE_02
            nxt_st.prev_gie    = 1'b1;
            nxt_st.redirect    = 1'b1;
            nxt_st.redirect_pc = {st_ff.epc, 1'b0};                                  // RULE_17
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff            <= '0;
            st_ff.inhibit    <= IMPL_INHIBIT;                                        // RULE_14
            st_ff.tvec_mode  <= TVEC_RESET_MODE[0];
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign csr_rdata              = st_ff.rdata;
    assign csr_rvalid             = st_ff.rvalid;
    assign csr_illegal            = st_ff.illegal;
    assign fetch_redirect         = st_ff.redirect;
    assign fetch_target           = st_ff.redirect_pc;
    assign global_irq_enable      = st_ff.gie;
    assign irq_enable_mask        = st_ff.irq_en;
    assign counter_inhibit_out    = st_ff.inhibit;
    assign trigger_execute_enable = st_ff.trig_execute;

    sequence s_trap;
        trap_in.take;
    endsequence

    a_trap_saves_enable: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_02
        s_trap |=> (st_ff.prev_gie == $past(st_ff.gie)) && !st_ff.gie)
        else $error("trap did not save global enable");
    a_mret_restores_enable: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_02
        (mret_in && !trap_in.take) |=> st_ff.gie == $past(st_ff.prev_gie))
        else $error("return did not restore global enable");
    a_prev_priv_fixed: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_01
        (csr_req.valid && csr_req.addr == ADDR_MACHINE_STATUS) |=> csr_rdata[12:11] == 2'b11)
        else $error("previous privilege not 11");
    a_isa_value: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_05
        (csr_req.valid && csr_req.addr == ADDR_ISA_DESCRIPTOR) |=> csr_rdata[31:30] == 2'b01
        && csr_rdata[12] && csr_rdata[8] && csr_rdata[2])
        else $error("isa descriptor wrong");
    a_tvec_low_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_10
        (csr_req.valid && csr_req.addr == ADDR_TRAP_VECTOR_BASE) |=> csr_rdata[7:1] == 7'h00)
        else $error("trap vector low bits not zero");
    a_trap_redirect: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_13
        s_trap |=> fetch_redirect && fetch_target[31:8] == $past(st_ff.tvec_base))
        else $error("trap redirect base wrong");
    a_epc_saved: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_17
        s_trap |=> st_ff.epc == $past(trap_in.pc[31:1]))
        else $error("exception pc not saved");
    a_trap_value_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_19
        (csr_req.valid && csr_req.addr == ADDR_TRAP_VALUE) |=> csr_rdata == 32'h0000_0000)
        else $error("trap value not zero");
    a_trig_machine_drop: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_21
        (csr_req.valid && csr_req.addr == ADDR_TRIGGER_DATA_ONE && !csr_req.debug_mode)
        |=> $stable(st_ff.trig_execute))
        else $error("machine mode trigger write took effect");
    a_cause_mid_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_18
        (csr_req.valid && csr_req.addr == ADDR_TRAP_CAUSE) |=> csr_rdata[30:5] == 26'h0)
        else $error("cause middle bits not zero");
    a_status_zero_bits: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_04
        (csr_req.valid && csr_req.addr == ADDR_MACHINE_STATUS) |=> (csr_rdata & 32'hffff_e777) == 32'h0000_0000)
        else $error("status reserved bits not zero");
    a_mret_redirect: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_17
        (mret_in && !trap_in.take) |=> fetch_redirect && fetch_target == {$past(st_ff.epc), 1'b0})
        else $error("return target not exception pc");
    a_evsel_upper_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_16
        (csr_req.valid && csr_req.addr >= ADDR_EVENT_SEL_FIRST && csr_req.addr <= ADDR_EVENT_SEL_LAST)
        |=> csr_rdata[31:16] == 16'h0000)
        else $error("event selector upper bits not zero");
    a_trig_type_fixed: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_22
        (csr_req.valid && csr_req.addr == ADDR_TRIGGER_DATA_ONE) |=> csr_rdata[31:28] == TRIG_TYPE_MATCH)
        else $error("trigger type not fixed");
    a_cause_write_legal: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_23
        (csr_req.valid && csr_req.addr == ADDR_TRAP_CAUSE) |=> !csr_illegal)
        else $error("cause access flagged illegal");
    // A line only moves once both late stages agree, so one-cycle glitches never reach pending
    a_pending_follows_sync: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE_09
        (st_ff.irq_sync2 == st_ff.irq_sync3) |=> st_ff.pending == ($past(st_ff.irq_sync2) & IRQ_LINE_MASK))
        else $error("pending does not follow synchronised lines");

endmodule : mtcsr_file
`default_nettype wire

// ==== rtl/mtcsr_pkg.sv ====
package mtcsr_pkg;

    localparam logic [11:0] ADDR_MACHINE_STATUS    = 12'h300;
    localparam logic [11:0] ADDR_ISA_DESCRIPTOR    = 12'h301;
    localparam logic [11:0] ADDR_INTERRUPT_ENABLE  = 12'h304;
    localparam logic [11:0] ADDR_TRAP_VECTOR_BASE  = 12'h305;
    localparam logic [11:0] ADDR_COUNTER_INHIBIT   = 12'h320;
    localparam logic [11:0] ADDR_EVENT_SEL_FIRST   = 12'h323;
    localparam logic [11:0] ADDR_EVENT_SEL_LAST    = 12'h33f;
    localparam logic [11:0] ADDR_TRAP_SCRATCH      = 12'h340;
    localparam logic [11:0] ADDR_EXCEPTION_PC      = 12'h341;
    localparam logic [11:0] ADDR_TRAP_CAUSE        = 12'h342;
    localparam logic [11:0] ADDR_TRAP_VALUE        = 12'h343;
    localparam logic [11:0] ADDR_INTERRUPT_PENDING = 12'h344;
    localparam logic [11:0] ADDR_TRIGGER_SELECT    = 12'h7a0;
    localparam logic [11:0] ADDR_TRIGGER_DATA_ONE  = 12'h7a1;

    // Machine status field positions
    localparam int MST_GLOBAL_ENABLE_BIT = 3;
    localparam int MST_PREV_ENABLE_BIT   = 7;
    localparam int MST_PREV_PRIV_LO      = 11;
    localparam logic [1:0] MST_PREV_PRIV_VALUE = 2'h3;

    // ISA descriptor letters
    localparam int ISA_XLEN_LO   = 30;
    localparam logic [1:0] ISA_XLEN_32 = 2'h1;
    localparam int ISA_BIT_C     = 2;
    localparam int ISA_BIT_F     = 5;
    localparam int ISA_BIT_I     = 8;
    localparam int ISA_BIT_M     = 12;
    localparam int ISA_BIT_X     = 23;

    // Interrupt lines: fast 31:16, external 11, timer 7, software 3
    localparam logic [31:0] IRQ_LINE_MASK = 32'hffff_0888;

    localparam int TVEC_BASE_LO = 8;
    localparam logic [5:0] TVEC_LOW_ZERO = 6'h00;
    localparam logic [1:0] TVEC_RESET_MODE = 2'h1;

    localparam int INH_CYCLE_BIT   = 0;
    localparam int INH_RETIRED_BIT = 2;
    localparam int INH_EVENT_LO    = 3;

    localparam int EVSEL_WIDTH = 16;
    localparam int CAUSE_INT_BIT = 31;
    localparam int CAUSE_CODE_W  = 5;

    localparam logic [3:0]  TRIG_TYPE_MATCH = 4'h2;
    localparam int          TRIG_EXECUTE_BIT = 2;
    localparam logic [31:0] TRIG_FIXED_VALUE = 32'h2800_1040;

    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        MTCSR_OP_WRITE = 2'b01,
        MTCSR_OP_SET   = 2'b10,
        MTCSR_OP_CLEAR = 2'b11
    } mtcsr_op_t;

    typedef struct packed {
        logic        valid;
        mtcsr_op_t   op;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        debug_mode;
    } mtcsr_req_t;

    typedef struct packed {
        logic        take;
        logic        interrupt;
        logic [4:0]  code;
        logic [31:0] pc;
    } mtcsr_trap_t;

    typedef struct packed {
        logic        gie;
        logic        prev_gie;
        logic [31:0] irq_en;
        logic [23:0] tvec_base;
        logic        tvec_mode;
        logic [31:0] inhibit;
        logic [28:0][EVSEL_WIDTH-1:0] evsel;
        logic [31:0] scratch;
        logic [30:0] epc;
        logic        cause_int;
        logic [4:0]  cause_code;
        logic        trig_execute;
        logic [31:0] irq_sync1;
        logic [31:0] irq_sync2;
        logic [31:0] irq_sync3;
        logic [31:0] pending;
        logic [31:0] rdata;
        logic        rvalid;
        logic        illegal;
        logic        redirect;
        logic [31:0] redirect_pc;
        logic        tvec_ready;
    } mtcsr_state_t;

endpackage : mtcsr_pkg

// ==== testbench/machine_trap_csr_file_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module machine_trap_csr_file_tb;
    import mtcsr_pkg::*;
    logic        sys_clk, arst_n, mret_in, ill;
    logic [31:0] boot_trap_base, irq_lines, csr_rdata, fetch_target, irq_enable_mask, counter_inhibit_out;
    logic        csr_rvalid, csr_illegal, fetch_redirect, global_irq_enable, trigger_execute_enable;
    mtcsr_req_t  csr_req;
    mtcsr_trap_t trap_in;
    logic [31:0] v, r1, r2, r3, tr[16], tm[16], tf[16], tv[16];
    logic [11:0] ta[16];
    int          err_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    mtcsr_file #(.FPU_PARAM(1), .CLUSTER_PARAM(1), .NUM_EVENT_COUNTERS(1)) i_mtcsr_file (
        .sys_clk(sys_clk), .arst_n(arst_n), .boot_trap_base(boot_trap_base), .csr_req(csr_req),
        .trap_in(trap_in), .mret_in(mret_in), .irq_lines(irq_lines), .csr_rdata(csr_rdata),
        .csr_rvalid(csr_rvalid), .csr_illegal(csr_illegal), .fetch_redirect(fetch_redirect),
        .fetch_target(fetch_target), .global_irq_enable(global_irq_enable),
        .irq_enable_mask(irq_enable_mask), .counter_inhibit_out(counter_inhibit_out),
        .trigger_execute_enable(trigger_execute_enable));

    mtcsr_core i_mtcsr_core (.sys_clk(sys_clk), .csr_req(csr_req), .trap_in(trap_in), .mret_in(mret_in));

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Answers are matched to notes in issue order
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (csr_rvalid === 1'b1) begin
            check({csr_illegal, csr_rdata},
                  i_mtcsr_core.exp_q.size() ? i_mtcsr_core.exp_q.pop_front() : 'x);
        end
        if (fetch_redirect === 1'b1) begin
            check(33'(fetch_target),
                  i_mtcsr_core.tgt_q.size() ? 33'(i_mtcsr_core.tgt_q.pop_front()) : 'x);
        end
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        arst_n = 1'b0;
        irq_lines = '0;
        boot_trap_base = 32'h8000_12ab;
        void'($urandom(32'hef28a060));
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        ta = '{12'h300, 12'h301, 12'h304, 12'h305, 12'h320, 12'h323, 12'h324, 12'h33f,
               12'h340, 12'h341, 12'h342, 12'h343, 12'h344, 12'h7a0, 12'h7a1, 12'h345};
        tr = '{32'h1800, 32'h4080_1124, '0, {boot_trap_base[31:8], 8'h01}, 32'hd, '0, '0, '0,
               '0, '0, '0, '0, '0, '0, 32'h2800_1040, '0};
        tm = '{32'h8, '0, 32'hffff_0888, 32'hffff_ff01, 32'hd, 32'hffff, '0, '0,
               32'hffff_ffff, 32'hffff_fffe, 32'h8000_001f, '0, '0, '0, '0, '0};
        tf = '{32'h1800, 32'h4080_1124, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, 32'h2800_1040, '0};
        for (int i = 0; i < 16; i++) begin
            r1 = $urandom;
            r2 = $urandom;
            r3 = $urandom;
            ill = (i == 15);
            v = tr[i];
            i_mtcsr_core.csr(MTCSR_OP_WRITE, ta[i], r1, 1'b0, {ill, v});
            v = (r1 & tm[i]) | tf[i];
            i_mtcsr_core.csr(MTCSR_OP_SET, ta[i], r2, 1'b0, {ill, v});
            v = ((v | r2) & tm[i]) | tf[i];
            i_mtcsr_core.csr(MTCSR_OP_CLEAR, ta[i], r3, 1'b0, {ill, v});
            v = (v & ~r3 & tm[i]) | tf[i];
            i_mtcsr_core.csr(MTCSR_OP_SET, ta[i], '0, 1'b0, {ill, v});
            tv[i] = v;
        end
        i_mtcsr_core.rest();
        check(33'(irq_enable_mask), 33'(tv[2]));
        check(33'(counter_inhibit_out), 33'(tv[4]));
        check(33'(global_irq_enable), 33'(tv[0][3]));
        i_mtcsr_core.csr(MTCSR_OP_WRITE, 12'h300, 32'h8, 1'b0, {1'b0, tv[0]});
        i_mtcsr_core.csr(MTCSR_OP_WRITE, 12'h305, 32'h1234_5601, 1'b0, {1'b0, tv[3]});
        i_mtcsr_core.rest();
        i_mtcsr_core.trap(1'b0, 5'h05, 32'h0000_1235, 32'h1234_5600);
        i_mtcsr_core.rest();
        check(33'(global_irq_enable), 33'h0);
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h300, '0, 1'b0, {1'b0, 32'h1880});
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h341, '0, 1'b0, {1'b0, 32'h1234});
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h342, '0, 1'b0, {1'b0, 32'h5});
        i_mtcsr_core.rest();
        i_mtcsr_core.ret(32'h1234);
        i_mtcsr_core.rest();
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h300, '0, 1'b0, {1'b0, 32'h1888});
        i_mtcsr_core.rest();
        i_mtcsr_core.trap(1'b1, 5'h07, 32'h2000, 32'h1234_561c);
        i_mtcsr_core.rest();
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h342, '0, 1'b0, {1'b0, 32'h8000_0007});
        i_mtcsr_core.csr(MTCSR_OP_WRITE, 12'h305, 32'h1234_5600, 1'b0, {1'b0, 32'h1234_5601});
        i_mtcsr_core.rest();
        i_mtcsr_core.trap(1'b1, 5'h07, 32'h2000, 32'h1234_5600);
        i_mtcsr_core.rest();
        // Debug-mode writes reach only the execute bit
        i_mtcsr_core.csr(MTCSR_OP_WRITE, 12'h7a1, 32'hffff_ffff, 1'b1, {1'b0, 32'h2800_1040});
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h7a1, '0, 1'b1, {1'b0, 32'h2800_1044});
        i_mtcsr_core.rest();
        check(33'(trigger_execute_enable), 33'h1);
        irq_lines <= $urandom;
        repeat (6) i_mtcsr_core.rest();
        i_mtcsr_core.csr(MTCSR_OP_WRITE, 12'h344, 32'hffff_ffff, 1'b0, {1'b0, irq_lines & 32'hffff_0888});
        // Flip every line so both rising and falling levels must reach pending
        irq_lines <= ~irq_lines;
        repeat (6) i_mtcsr_core.rest();
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h344, '0, 1'b0, {1'b0, irq_lines & 32'hffff_0888});
        repeat (3) i_mtcsr_core.rest();
        arst_n <= 1'b0;
        boot_trap_base <= $urandom;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h305, '0, 1'b0, {1'b0, boot_trap_base[31:8], 8'h01});
        i_mtcsr_core.csr(MTCSR_OP_SET, 12'h320, '0, 1'b0, {1'b0, 32'hd});
        repeat (3) i_mtcsr_core.rest();
        check(33'(i_mtcsr_core.exp_q.size() + i_mtcsr_core.tgt_q.size()), 33'h0);
        print_verdict();
    end
endmodule : machine_trap_csr_file_tb
`default_nettype wire

// ==== testbench/mtcsr_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module mtcsr_core
    import mtcsr_pkg::*;
(
    input  wire logic      sys_clk,
    output var mtcsr_req_t  csr_req,
    output var mtcsr_trap_t trap_in,
    output var logic        mret_in
);
    logic [32:0] exp_q[$];
    logic [31:0] tgt_q[$];

    initial begin
        csr_req = '0;
        trap_in = '0;
        mret_in = 1'b0;
    end

    // Idle lanes carry junk so the block must key on the strobes alone
    task automatic rest();
        csr_req <= mtcsr_req_t'({1'b0, 15'($urandom), $urandom});
        trap_in <= mtcsr_trap_t'({1'b0, 6'($urandom), $urandom});
        mret_in <= 1'b0;
        @(posedge sys_clk);
    endtask : rest

    // Held until the next edge; caller follows with another access or rest
    task automatic csr(input mtcsr_op_t op, input logic [11:0] a, input logic [31:0] wd,
                       input logic dbg, input logic [32:0] exp);
        csr_req <= '{valid: 1'b1, op: op, addr: a, wdata: wd, debug_mode: dbg};
        exp_q.push_back(exp);
        @(posedge sys_clk);
    endtask : csr

    task automatic trap(input logic irq, input logic [4:0] code, input logic [31:0] pc,
                        input logic [31:0] tgt);
        trap_in <= '{take: 1'b1, interrupt: irq, code: code, pc: pc};
        tgt_q.push_back(tgt);
        @(posedge sys_clk);
    endtask : trap

    task automatic ret(input logic [31:0] tgt);
        mret_in <= 1'b1;
        tgt_q.push_back(tgt);
        @(posedge sys_clk);
    endtask : ret
endmodule : mtcsr_core
`default_nettype wire
